// [rtl/dvmoc_pkg.sv]
/*
 * constants for the playback volume, soft silence and output control block.
 * assumes one system clock and a one-cycle sample strobe at the rate fs.
 */
`default_nettype none
package dvmoc_pkg;
	// volume codes
	localparam logic [7:0] VOL_CODE_MAX = 8'h00; // +12 dB
	localparam logic [7:0] VOL_CODE_RESET = 8'h18; // 0 dB
	localparam logic [7:0] VOL_CODE_MUTE = 8'hFF; // silence
	// internal attenuation levels: 1062 levels, 0..1061
	localparam int RAMP_LEVELS = 1062;
	localparam int SLOW_RAMP_SAMPLES = 1061;
	localparam int FAST_RAMP_SAMPLES = 256;
	localparam logic [10:0] LEVEL_MUTE = 11'h425; // 1061
	// fast: per code 4 levels plus mute step; slow: one level per sample
	localparam logic [10:0] SLOW_STEP = 11'h004;
	localparam logic [10:0] FAST_STEP = 11'h004;
	localparam logic [10:0] SLOW_DELTA = 11'h001;
	localparam logic [10:0] LEVEL_RESET = 11'h060; // code 18H times 4
	// last fast-grid level (code FFH times 4); fast mode jumps from here to mute
	localparam logic [10:0] FAST_TOP = 11'h3FC; // 1020
	// gain table fraction bits (gain scaled by 2^14 at 0 dB)
	localparam int GAIN_FRAC = 14;
	localparam int GAIN_W = 18;
	// unity gain, the gain of LEVEL_RESET
	localparam logic [GAIN_W-1:0] GAIN_RESET = 18'h04000;
	// line output modes
	typedef enum logic [1:0] {
		DVMOC_LINE_OFF = 2'b00,
		DVMOC_LINE_RUN = 2'b01,
		DVMOC_LINE_FALL = 2'b10,
		DVMOC_LINE_RISE = 2'b11
	} dvmoc_line_mode_t;
	// sample pair buffer depth
	localparam int BUF_DEPTH = 2;
endpackage
`default_nettype wire

// [rtl/dvmoc_gain_rom.sv]
/*
 * registered gain table: attenuation level to linear gain.
 * assumes the caller holds the level steady while it needs the gain.
 */
`default_nettype none
module dvmoc_gain_rom
	import dvmoc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [10:0] level,
	output logic [GAIN_W-1:0] gain
);
	// 4 levels per 0.5 dB step: each level is 0.125 dB, 48 levels per 6 dB
	logic [8:0] mant [0:47];
	logic [5:0] octave;
	logic [5:0] frac;
	logic [GAIN_W-1:0] gainD;
	logic [10:0] levelQ;

	// mantissa table 2^(-k/48) scaled by 256, filled by a loop
	genvar k;
	generate
		for (k = 0; k < 48; k++) begin : g_mant
			assign mant[k] = 9'(int'(256.0 * (2.0 ** (-real'(k) / 48.0))));
		end
	endgenerate

	// split level into 6 dB octaves and the fraction within
	assign octave = 6'(levelQ / 11'd48);
	assign frac = 6'(levelQ % 11'd48);
	// mantissa 256 is 1.0; the extra 2 puts level 0 at four times unity
	assign gainD = (levelQ >= LEVEL_MUTE) ? '0 :
		GAIN_W'((({9'h000, mant[frac]} << (GAIN_FRAC - 8 + 2)))
		>> octave);

	// register level then gain so the read data comes from a flip-flop
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			levelQ <= LEVEL_RESET;
			gain <= GAIN_RESET; // matches the reset level, no dead first word
		end else begin
			levelQ <= level;
			gain <= gainD;
		end
	end
endmodule // dvmoc_gain_rom
`default_nettype wire

// [rtl/dvmoc_core.sv]
/*
 * playback volume with soft ramps, soft silence, and output path control.
 * assumes a one-cycle sampleStrobe per sample period, and sample pairs
 * offered with valid/ready; control bits come straight from host logic.
 */
`default_nettype none
module dvmoc_core
	import dvmoc_pkg::*;
#(
	parameter int SAMPLE_W = 16
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic sampleStrobe,
	input wire logic [SAMPLE_W-1:0] inLeft,
	input wire logic [SAMPLE_W-1:0] inRight,
	input wire logic inValid,
	output logic inReady,
	output logic [SAMPLE_W-1:0] outLeft,
	output logic [SAMPLE_W-1:0] outRight,
	output logic outValid,
	input wire logic outReady,
	input wire logic [7:0] left_volume_code,
	input wire logic [7:0] right_volume_code,
	input wire logic common_volume_select,
	input wire logic volume_ramp_time_select,
	input wire logic soft_silence_request,
	input wire logic mono_input_power,
	input wire logic mono_to_headphone_route,
	input wire logic mono_to_line_route,
	input wire logic dac_to_line_route,
	input wire logic line_output_power,
	input wire logic line_output_power_save,
	input wire logic line_output_gain_select,
	input wire logic headphone_gain_select,
	input wire logic headphone_common_enable,
	input wire logic headphone_left_power,
	input wire logic headphone_right_power,
	output logic monoPowerOn,
	output logic monoToHeadphoneOn,
	output logic monoToLineOn,
	output logic lineDacDrive,
	output logic [1:0] lineMode,
	output logic lineGainHigh,
	output logic headphoneSwingHigh,
	output logic headphoneCommonUp,
	output logic headphoneAmpOn,
	output logic headphoneOutsLow,
	output logic leftMuted,
	output logic rightMuted
);
	logic [10:0] levelLQ, levelLD, levelRQ, levelRD;
	logic [10:0] targetL, targetR;
	logic [7:0] codeR;
	logic [GAIN_W-1:0] gainL, gainR;
	logic [SAMPLE_W-1:0] spareLQ, spareRQ, headLD, headRD;
	logic spareFull, headFree, doTake, headLoad, spareLoad, validD, readyD;
	logic [SAMPLE_W+GAIN_W-1:0] prodL, prodR;
	logic [SAMPLE_W-1:0] scaledL, scaledR;
	logic [10:0] stepL, stepR;

	// right code follows left when common select is set
	assign codeR = common_volume_select ? left_volume_code : right_volume_code;

	// target level: code times 4, mute code and soft silence go to full mute
	function automatic logic [10:0] codeToLevel(input logic [7:0] code,
		input logic silence);
		logic [10:0] lvl;
		lvl = {1'b0, code, 2'b00};
		if (silence || code == VOL_CODE_MUTE) begin
			lvl = LEVEL_MUTE;
		end
		return lvl;
	endfunction
	assign targetL = codeToLevel(left_volume_code, soft_silence_request);
	assign targetR = codeToLevel(codeR, soft_silence_request);

	// fast mode steps 4 levels per sample, slow mode one
	assign stepL = volume_ramp_time_select ? FAST_STEP : SLOW_DELTA;
	assign stepR = stepL;

	// move each level toward its target, never overshooting; in fast mode
	// the band above the last grid point is crossed in one step, so the
	// whole range is 255 grid steps plus one mute step
	function automatic logic [10:0] rampNext(input logic [10:0] cur,
		input logic [10:0] tgt, input logic [10:0] step,
		input logic fast);
		logic [10:0] nxt;
		nxt = cur;
		if (fast && cur >= FAST_TOP && tgt > cur) begin
			nxt = tgt;
		end else if (fast && cur > FAST_TOP && tgt < FAST_TOP) begin
			nxt = FAST_TOP;
		end else if (tgt > cur) begin
			nxt = (tgt - cur > step) ? 11'(cur + step) : tgt;
		end else if (tgt < cur) begin
			nxt = (cur - tgt > step) ? 11'(cur - step) : tgt;
		end
		return nxt;
	endfunction
	assign levelLD = sampleStrobe ?
		rampNext(levelLQ, targetL, stepL, volume_ramp_time_select) :
		levelLQ;
	assign levelRD = sampleStrobe ?
		rampNext(levelRQ, targetR, stepR, volume_ramp_time_select) :
		levelRQ;

	// applied attenuation levels
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			levelLQ <= LEVEL_RESET;
			levelRQ <= LEVEL_RESET;
		end else begin
			levelLQ <= levelLD;
			levelRQ <= levelRD;
		end
	end

	// gain lookups, registered inside
	dvmoc_gain_rom u_romL (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.level(levelLQ),
		.gain(gainL)
	);
	dvmoc_gain_rom u_romR (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.level(levelRQ),
		.gain(gainR)
	);

	// scale samples; 4x gain at +12 dB fits by saturating
	assign prodL = (SAMPLE_W+GAIN_W)'($signed(inLeft) *
		$signed({1'b0, gainL}));
	assign prodR = (SAMPLE_W+GAIN_W)'($signed(inRight) *
		$signed({1'b0, gainR}));
	function automatic logic [SAMPLE_W-1:0] sat(
		input logic [SAMPLE_W+GAIN_W-1:0] p);
		logic signed [SAMPLE_W+GAIN_W-1:0] s;
		logic signed [SAMPLE_W+GAIN_W-1:0] hi, lo;
		s = $signed(p) >>> GAIN_FRAC;
		hi = (SAMPLE_W+GAIN_W)'((1 <<< (SAMPLE_W - 1)) - 1);
		lo = -hi - 1;
		if (s > hi) begin
			s = hi;
		end else if (s < lo) begin
			s = lo;
		end
		return s[SAMPLE_W-1:0];
	endfunction
	assign scaledL = sat(prodL);
	assign scaledR = sat(prodR);

	// two-entry buffer: the output word plus one spare, so a word that
	// arrives while the receiver stalls is kept, not lost
	assign spareFull = !inReady; // spare in use exactly when not ready
	assign headFree = !outValid || outReady;
	assign doTake = inValid && inReady;
	assign headLoad = headFree && (spareFull || doTake);
	assign spareLoad = !headFree && doTake;
	assign validD = !headFree || spareFull || doTake;
	assign readyD = headFree || !(spareFull || doTake);
	assign headLD = spareFull ? spareLQ : scaledL;
	assign headRD = spareFull ? spareRQ : scaledR;

	// buffer flags, registered straight onto the ports
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			outValid <= 1'b0;
			inReady <= 1'b1;
		end else begin
			outValid <= validD;
			inReady <= readyD;
		end
	end

	// output word and spare word; the spare drains first to keep order
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			outLeft <= '0;
			outRight <= '0;
			spareLQ <= '0;
			spareRQ <= '0;
		end else begin
			if (headLoad) begin
				outLeft <= headLD;
				outRight <= headRD;
			end
			if (spareLoad) begin
				spareLQ <= scaledL;
				spareRQ <= scaledR;
			end
		end
	end

	// analog path control, all registered
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			monoPowerOn <= 1'b0;
			monoToHeadphoneOn <= 1'b0;
			monoToLineOn <= 1'b0;
			lineDacDrive <= 1'b0;
			lineMode <= DVMOC_LINE_OFF;
			lineGainHigh <= 1'b0;
			headphoneSwingHigh <= 1'b0;
			headphoneCommonUp <= 1'b0;
			headphoneAmpOn <= 1'b0;
			headphoneOutsLow <= 1'b1;
			leftMuted <= 1'b0;
			rightMuted <= 1'b0;
		end else begin
			monoPowerOn <= mono_input_power;
			monoToHeadphoneOn <= mono_input_power && mono_to_headphone_route;
			monoToLineOn <= mono_input_power && mono_to_line_route;
			lineDacDrive <= dac_to_line_route;
			lineMode <= {line_output_power_save, line_output_power};
			lineGainHigh <= line_output_gain_select;
			headphoneSwingHigh <= headphone_gain_select;
			headphoneCommonUp <= headphone_common_enable;
			headphoneAmpOn <= headphone_left_power || headphone_right_power;
			headphoneOutsLow <= !headphone_common_enable ||
				!(headphone_left_power || headphone_right_power);
			leftMuted <= (levelLQ == LEVEL_MUTE);
			rightMuted <= (levelRQ == LEVEL_MUTE);
		end
	end

	// checks
	ramp_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!sampleStrobe |=> levelLQ == $past(levelLQ))
		else $error("level moved without sample strobe");
	ramp_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sampleStrobe && levelLQ < FAST_TOP |=>
		(levelLQ <= $past(levelLQ) + 11'd4 &&
		levelLQ + 11'd4 >= $past(levelLQ)))
		else $error("ramp step too large");
	fast_top_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sampleStrobe && volume_ramp_time_select &&
		levelLQ >= FAST_TOP && targetL == LEVEL_MUTE |=>
		levelLQ == LEVEL_MUTE)
		else $error("fast ramp did not close the mute step");
	muted_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> leftMuted == ($past(levelLQ) == LEVEL_MUTE))
		else $error("left mute flag does not follow level");
	silence_right_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		soft_silence_request |-> targetR == LEVEL_MUTE)
		else $error("silence does not aim right at mute");
	spare_valid_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!inReady |-> outValid)
		else $error("spare word held without an output word");
	slow_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sampleStrobe && !volume_ramp_time_select |=>
		(levelLQ <= $past(levelLQ) + 11'd1 &&
		levelLQ + 11'd1 >= $past(levelLQ)))
		else $error("slow ramp faster than one level");
	common_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		common_volume_select |-> targetR == targetL)
		else $error("right target differs under common select");
	silence_tgt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		soft_silence_request |-> targetL == LEVEL_MUTE)
		else $error("silence does not aim at mute");
	line_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> lineMode == {$past(line_output_power_save),
		$past(line_output_power)})
		else $error("line mode wrong");
	hp_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!headphone_left_power && !headphone_right_power |=>
		headphoneOutsLow && !headphoneAmpOn)
		else $error("headphone not held low");
	buf_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		outValid && !outReady |=> outValid && $stable(outLeft))
		else $error("buffer lost word under stall");
	mono_pwr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!mono_input_power |=> !monoPowerOn && !monoToLineOn)
		else $error("mono path on without power");
	cov_silence: cover property (@(posedge clk_sys) disable iff (!rst_n)
		leftMuted && soft_silence_request);
	cov_fast: cover property (@(posedge clk_sys) disable iff (!rst_n)
		sampleStrobe && volume_ramp_time_select && levelLQ != levelLD);
	cov_full: cover property (@(posedge clk_sys) disable iff (!rst_n)
		!inReady);
	cov_fast_top: cover property (@(posedge clk_sys) disable iff (!rst_n)
		sampleStrobe && volume_ramp_time_select && levelLQ == FAST_TOP);
	cov_release: cover property (@(posedge clk_sys) disable iff (!rst_n)
		!soft_silence_request && levelLQ > LEVEL_RESET && !leftMuted);
endmodule // dvmoc_core
`default_nettype wire

// [test/dvmoc_host_model.sv]
/*
 * host model: writes the output path control bits in pop-safe order.
 * assumes the bench calls its tasks; SETTLE cycles stand for analog waits.
 */
`default_nettype none
module dvmoc_host_model #(
	parameter int SETTLE = 40
)(
	input wire logic clk_sys,
	output var logic mono_input_power = 1'h0,
	output var logic mono_to_headphone_route = 1'h0,
	output var logic mono_to_line_route = 1'h0,
	output var logic dac_to_line_route = 1'h0,
	output var logic line_output_power = 1'h0,
	output var logic line_output_power_save = 1'h0,
	output var logic line_output_gain_select = 1'h0,
	output var logic headphone_gain_select = 1'h0,
	output var logic headphone_common_enable = 1'h0,
	output var logic headphone_left_power = 1'h0,
	output var logic headphone_right_power = 1'h0
);
	timeunit 1ns;
	timeprecision 100ps;
	// writes land just after a clock edge
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// mono path, DAC-to-line route and gain bits carry no ordering duty
	task automatic mix(input logic [5:0] r);
		step(1);
		{mono_input_power, mono_to_headphone_route, mono_to_line_route,
			dac_to_line_route, line_output_gain_select,
			headphone_gain_select} = r;
	endtask
	// line output up then down, always through power-save
	task automatic lineCycle();
		step(1);
		line_output_power_save = 1'h1;
		step(3);
		line_output_power = 1'h1;
		step(SETTLE);
		line_output_power_save = 1'h0;
		step(SETTLE);
		line_output_power_save = 1'h1;
		step(3);
		line_output_power = 1'h0;
		step(SETTLE);
		line_output_power_save = 1'h0;
	endtask
	// channels before common; common falls before power goes
	task automatic hpCycle();
		step(1);
		headphone_left_power = 1'h1;
		step(2);
		headphone_right_power = 1'h1;
		step(2);
		headphone_common_enable = 1'h1;
		step(SETTLE);
		headphone_common_enable = 1'h0;
		step(SETTLE);
		{headphone_left_power, headphone_right_power} = 2'h0;
	endtask
endmodule // dvmoc_host_model
`default_nettype wire

// [test/dac_volume_mute_output_ctrl_test.sv]
/*
 * self-checking bench for playback volume, soft silence and output control.
 * assumes a sample strobe every 4 clocks and the host model for path bits.
 */
`default_nettype none
module dac_volume_mute_output_ctrl_test
	import dvmoc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 0, rst_n = 0, sampleStrobe = 0, inValid = 0, outReady = 0;
	logic [15:0] inLeft = 0, inRight = 0;
	logic [7:0] left_volume_code = VOL_CODE_RESET;
	logic [7:0] right_volume_code = VOL_CODE_RESET;
	logic common_volume_select = 0, volume_ramp_time_select = 0;
	logic soft_silence_request = 0, stall = 0, run = 0;
	wire logic mono_input_power, mono_to_headphone_route, mono_to_line_route;
	wire logic dac_to_line_route, line_output_power, line_output_power_save;
	wire logic line_output_gain_select, headphone_gain_select;
	wire logic headphone_common_enable, headphone_left_power;
	wire logic headphone_right_power, inReady, outValid, monoPowerOn;
	wire logic monoToHeadphoneOn, monoToLineOn, lineDacDrive, lineGainHigh;
	wire logic headphoneSwingHigh, headphoneCommonUp, headphoneAmpOn;
	wire logic headphoneOutsLow, leftMuted, rightMuted;
	wire logic [15:0] outLeft, outRight;
	wire logic [1:0] lineMode;
	int bad_count = 0, compares = 0, dexp = 1, tick = 0, n;
	logic [31:0] seed = 32'h8759;
	logic [33:0] sb[$];
	logic [10:0] ctlQ = 0;
	wire logic [10:0] ctlNow = {mono_input_power, mono_to_headphone_route,
		mono_to_line_route, dac_to_line_route, line_output_power,
		line_output_power_save, line_output_gain_select, headphone_gain_select,
		headphone_common_enable, headphone_left_power, headphone_right_power};
	wire logic [10:0] ctlGot = {monoPowerOn, monoToHeadphoneOn, monoToLineOn,
		lineDacDrive, lineMode, lineGainHigh, headphoneSwingHigh,
		headphoneCommonUp, headphoneAmpOn, headphoneOutsLow};
	dvmoc_core #(.SAMPLE_W(16)) i_dut (.*);
	dvmoc_host_model #(.SETTLE(40)) i_host (.*);
	always #25 clk_sys = ~clk_sys;
	// helpers: random source, expected path outputs
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [10:0] expCtl(input logic [10:0] c);
		return {c[10], c[9] & c[10], c[8] & c[10], c[7], c[5], c[6], c[4:2],
			c[1] | c[0], ~c[2] | ~(c[1] | c[0])};
	endfunction
	// reporting and compares
	task automatic fail(input string m);
		bad_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic chkBits(input logic [10:0] g, e);
		compares++;
		if (g !== e) fail($sformatf("bits %h exp %h", g, e));
	endtask
	task automatic chkSmp(input logic [15:0] g, e);
		int d;
		compares++;
		d = int'($signed(g)) - int'($signed(e));
		if (^g === 1'bx || d > 1 || d < -1) fail($sformatf("smp %h exp %h", g, e));
	endtask
	task automatic chkN(input int v, lo, hi);
		compares++;
		if (v < lo || v > hi) fail($sformatf("count %0d not %0d..%0d", v, lo, hi));
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	// counts sample periods until a mute flag reaches the wanted level
	task automatic ramp(input logic rgt, want, input int lo, hi);
		n = 0;
		while ((rgt ? rightMuted : leftMuted) !== want && n < 4 * hi + 40) begin
			cyc(1);
			n++;
		end
		if (n >= 4 * hi + 40) begin
			fail("ramp timeout");
			finish_test();
		end
		chkN((n + 3) / 4, lo, hi);
	endtask
	// path outputs follow the host bits one clock later
	always @(posedge clk_sys) ctlQ <= ctlNow;
	always @(negedge clk_sys) if (rst_n) chkBits(ctlGot, expCtl(ctlQ));
	// stream source, stalling sink, scoreboard; mode 1 unity, 2 silent
	always @(posedge clk_sys) begin
		logic [33:0] e;
		logic tk;
		tk = inValid && inReady;
		if (tk) sb.push_back({dexp[1:0], inLeft, inRight});
		if (outValid && outReady) begin
			if (sb.size() == 0) fail("extra word");
			else begin
				e = sb.pop_front();
				if (e[33:32] != 0) begin
					chkSmp(outLeft, e[33] ? 16'h0 : e[31:16]);
					chkSmp(outRight, e[33] ? 16'h0 : e[15:0]);
				end
			end
		end
		tick++;
		#1;
		sampleStrobe = (tick % 4 == 0);
		seed = xs(seed);
		if (tk || !inValid) {inLeft, inRight} = seed;
		inValid = run;
		outReady = !stall && seed[7];
	end
	// main sequence
	initial begin
		cyc(10);
		rst_n = 1;
		run = 1;
		fork
			i_host.lineCycle();
			i_host.hpCycle();
			repeat (80) i_host.mix(seed[12:7]);
		join
		$display("path test done");
		stall = 1;
		n = 0;
		while (inReady !== 1'b0 && n < 20) begin
			cyc(1);
			n++;
		end
		if (n == 20) begin
			fail("buffer never full");
			finish_test();
		end
		chkN(sb.size(), BUF_DEPTH, BUF_DEPTH);
		stall = 0;
		$display("buffer test done");
		dexp = 0;
		volume_ramp_time_select = 1;
		right_volume_code = VOL_CODE_MAX;
		cyc(120);
		// full range 00H to mute: 256 samples, plus one for the flag
		right_volume_code = VOL_CODE_MUTE;
		ramp(1, 1, 256, 257);
		common_volume_select = 1;
		ramp(1, 0, 1, 2);
		cyc(1000);
		dexp = 1;
		cyc(100);
		common_volume_select = 0;
		right_volume_code = VOL_CODE_RESET;
		$display("channel test done");
		soft_silence_request = 1;
		dexp = 0;
		cyc(400);
		soft_silence_request = 0;
		cyc(600);
		dexp = 1;
		cyc(100);
		soft_silence_request = 1;
		dexp = 0;
		// from 0 dB: 231 fast grid steps, then the single mute step
		ramp(0, 1, 232, 233);
		cyc(20);
		dexp = 2;
		cyc(100);
		soft_silence_request = 0;
		dexp = 0;
		ramp(0, 0, 1, 2);
		cyc(1100);
		dexp = 1;
		cyc(100);
		$display("silence test done");
		dexp = 0;
		volume_ramp_time_select = 0;
		left_volume_code = VOL_CODE_MAX;
		cyc(500);
		left_volume_code = VOL_CODE_MUTE;
		ramp(0, 1, 1060, 1063);
		left_volume_code = 8'hFE;
		ramp(0, 0, 1, 2);
		$display("slow ramp test done");
		finish_test();
	end
endmodule // dac_volume_mute_output_ctrl_test
`default_nettype wire
